/* File: inc/ccoc_pkg.sv */
// Constants, types and helpers for the channel output control block
package ccoc_pkg;

	// ****************************************************************
	// Bus geometry
	// ****************************************************************
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;

	// ****************************************************************
	// Control word field positions
	// ****************************************************************
	localparam int unsigned UF_ACT_HI = 13;
	localparam int unsigned UF_ACT_LO = 12;
	localparam int unsigned OF_ACT_HI = 11;
	localparam int unsigned OF_ACT_LO = 10;
	localparam int unsigned MT_ACT_HI = 9;
	localparam int unsigned MT_ACT_LO = 8;
	localparam int unsigned INIT_BIT  = 4;
	localparam int unsigned INV_BIT   = 2;
	localparam int unsigned MODE_HI   = 1;
	localparam int unsigned MODE_LO   = 0;
	localparam int unsigned BYTE_W    = 8;

	// Writable bits of the control word
	localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0000_3f17;
	localparam logic [DATA_W-1:0] CTRL_RST  = 32'h0000_0000;

	// Status word field positions
	localparam int unsigned ST_LEVEL_BIT = 0;
	localparam int unsigned ST_PIN_BIT   = 1;
	localparam int unsigned ST_RUN_BIT   = 2;
	localparam int unsigned ST_OE_BIT    = 3;

	// ****************************************************************
	// Encodings
	// ****************************************************************
	typedef enum logic [1:0] {
		ACT_NONE   = 2'h0,
		ACT_TOGGLE = 2'h1,
		ACT_CLEAR  = 2'h2,
		ACT_SET    = 2'h3
	} ccoc_act_t;

	typedef enum logic [1:0] {
		MODE_OFF         = 2'h0,
		capture_in_mode  = 2'h1,
		compare_out_mode = 2'h2,
		MODE_PWM         = 2'h3
	} ccoc_mode_t;

	// Channel sequence, Gray coded along off, hold, run
	typedef enum logic [1:0] {
		ST_OFF  = 2'b00,
		ST_HOLD = 2'b01,
		ST_RUN  = 2'b11
	} ccoc_state_t;

	// Applies one output action to the current level
	function automatic logic ccoc_apply(input ccoc_act_t act,
		input logic lvl);
		logic res;
		res = lvl;
		unique case (act)
			ACT_NONE:   res = lvl;
			ACT_TOGGLE: res = ~lvl;
			ACT_CLEAR:  res = 1'b0;
			ACT_SET:    res = 1'b1;
		endcase
		return res;
	endfunction

endpackage

/* File: inc/ccoc_if.sv */
// Carrier between the register front end and the output engine
`timescale 1ns/1ns
interface ccoc_if;
	ccoc_pkg::ccoc_act_t  underflow_out_action;
	ccoc_pkg::ccoc_act_t  overflow_out_action;
	ccoc_pkg::ccoc_act_t  match_out_action;
	logic                 out_initial_state;
	ccoc_pkg::ccoc_mode_t mode;
	logic                 underflow;
	logic                 overflow;
	logic                 match;
	logic                 running;
	logic                 level;
	logic                 drive;

	modport ctl (
		output underflow_out_action,
		output overflow_out_action,
		output match_out_action,
		output out_initial_state,
		output mode,
		output underflow,
		output overflow,
		output match,
		output running,
		input  level,
		input  drive
	);

	modport eng (
		input  underflow_out_action,
		input  overflow_out_action,
		input  match_out_action,
		input  out_initial_state,
		input  mode,
		input  underflow,
		input  overflow,
		input  match,
		input  running,
		output level,
		output drive
	);
endinterface

/* File: core/ccoc_engine.sv */
// Output level engine of one compare channel
`timescale 1ns/1ns
module ccoc_engine (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	ccoc_if.eng       cif
);

	// ****************************************************************
	// State
	// ****************************************************************
	ccoc_pkg::ccoc_state_t state_ff;
	ccoc_pkg::ccoc_state_t nxt_state;
	logic                  level_ff;
	logic                  nxt_level;
	logic                  is_out;

	assign is_out = (cif.mode == ccoc_pkg::compare_out_mode) ||
		(cif.mode == ccoc_pkg::MODE_PWM);
	assign cif.level = level_ff;
	assign cif.drive = (state_ff != ccoc_pkg::ST_OFF);

	// Next state and next output level
	always_comb begin
		nxt_state = state_ff;
		nxt_level = level_ff;
		unique case (state_ff)
			ccoc_pkg::ST_OFF: begin
				nxt_level = 1'b0;
				if (is_out) begin
					nxt_state = ccoc_pkg::ST_HOLD;
				end
			end
			ccoc_pkg::ST_HOLD: begin
				// Stopped level; pwm ignores the initial bit
				if (cif.mode == ccoc_pkg::compare_out_mode) begin
					nxt_level = cif.out_initial_state;
				end else begin
					nxt_level = 1'b0;
				end
				if (!is_out) begin
					nxt_state = ccoc_pkg::ST_OFF;
				end else if (cif.running) begin
					nxt_state = ccoc_pkg::ST_RUN;
				end
			end
			ccoc_pkg::ST_RUN: begin
				// Events applied in order underflow, overflow, match
				if (cif.underflow) begin
					nxt_level = ccoc_pkg::ccoc_apply(
						cif.underflow_out_action, nxt_level);
				end
				if (cif.overflow) begin
					nxt_level = ccoc_pkg::ccoc_apply(
						cif.overflow_out_action, nxt_level);
				end
				if (cif.match) begin
					nxt_level = ccoc_pkg::ccoc_apply(
						cif.match_out_action, nxt_level);
				end
				if (!is_out) begin
					nxt_state = ccoc_pkg::ST_OFF;
					nxt_level = 1'b0;
				end else if (!cif.running) begin
					nxt_state = ccoc_pkg::ST_HOLD;
				end
			end
			default: begin
				nxt_state = ccoc_pkg::ST_OFF;
				nxt_level = 1'b0;
			end
		endcase
	end

	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ccoc_pkg::ST_OFF;
			level_ff <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;
			level_ff <= nxt_level;
		end
	end

endmodule

/* File: core/ccoc_top.sv */
// Compare channel output control with its APB register front end
`timescale 1ns/1ns
module ccoc_top (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          ce,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [ccoc_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [ccoc_pkg::DATA_W-1:0]   pwdata,
	input  wire logic [ccoc_pkg::DATA_W/8-1:0] pstrb,
	output logic      [ccoc_pkg::DATA_W-1:0]   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          cnt_underflow,
	input  wire logic                          cnt_overflow,
	input  wire logic                          cmp_match,
	input  wire logic                          cnt_running,
	output logic                               cc_out,
	output logic                               cc_out_en
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [ccoc_pkg::DATA_W-1:0] ctrl_ff;
	logic [ccoc_pkg::DATA_W-1:0] nxt_ctrl;
	logic [ccoc_pkg::DATA_W-1:0] prdata_ff;
	logic [ccoc_pkg::DATA_W-1:0] nxt_prdata;
	logic                        pready_ff;
	logic                        nxt_pready;
	logic                        pslverr_ff;
	logic                        nxt_pslverr;
	logic                        cc_out_ff;
	logic                        nxt_cc_out;
	logic                        cc_out_en_ff;
	logic                        nxt_cc_out_en;
	logic                        setup;
	logic                        access_done;
	logic                        hit_ctrl;
	logic                        hit_status;
	logic [ccoc_pkg::DATA_W-1:0] wr_mask;
	logic [ccoc_pkg::DATA_W-1:0] status_word;
	logic                        out_invert;

	ccoc_if cif ();

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// Expands byte strobes into a bit mask
	function automatic logic [ccoc_pkg::DATA_W-1:0] strb_mask(
		input logic [ccoc_pkg::DATA_W/8-1:0] strb);
		logic [ccoc_pkg::DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < ccoc_pkg::DATA_W/8; i++) begin
			if (strb[i]) begin
				m[i*ccoc_pkg::BYTE_W +: ccoc_pkg::BYTE_W] = 8'hff;
			end
		end
		return m;
	endfunction

	// Matches an address against a register offset
	function automatic logic addr_hit(
		input logic [ccoc_pkg::ADDR_W-1:0] a,
		input logic [ccoc_pkg::ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	// ****************************************************************
	// APB decode
	// ****************************************************************

	// Setup phase and completing access phase
	assign setup       = psel && !penable;
	assign access_done = psel && penable && pready_ff;
	assign hit_ctrl    = addr_hit(paddr, ccoc_pkg::OFS_CTRL);
	assign hit_status  = addr_hit(paddr, ccoc_pkg::OFS_STATUS);
	assign wr_mask     = strb_mask(pstrb) & ccoc_pkg::CTRL_MASK;

	// Live channel state for the status word
	always_comb begin
		status_word = '0;
		status_word[ccoc_pkg::ST_LEVEL_BIT] = cif.level;
		status_word[ccoc_pkg::ST_PIN_BIT]   = cc_out_ff;
		status_word[ccoc_pkg::ST_RUN_BIT]   = cnt_running;
		status_word[ccoc_pkg::ST_OE_BIT]    = cc_out_en_ff;
	end

	// Bus answer: one wait-free access phase after setup
	always_comb begin
		nxt_pready  = 1'b0;
		nxt_pslverr = 1'b0;
		nxt_prdata  = '0;
		if (setup) begin
			nxt_pready  = 1'b1;
			nxt_pslverr = !(hit_ctrl || hit_status);
			if (!pwrite && hit_ctrl) begin
				nxt_prdata = ctrl_ff;
			end else if (!pwrite && hit_status) begin
				nxt_prdata = status_word;
			end
		end
	end

	// Control word update; unused bits never stored
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (access_done && pwrite && hit_ctrl) begin
			nxt_ctrl = (ctrl_ff & ~wr_mask) | (pwdata & wr_mask);
		end
	end

	// Bus registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff    <= ccoc_pkg::CTRL_RST;
			prdata_ff  <= '0;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else if (ce) begin
			ctrl_ff    <= nxt_ctrl;
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;

	// ****************************************************************
	// Field fan-out to the engine and the pin stage
	// ****************************************************************

	// Action, initial state, mode and invert fields
	assign cif.underflow_out_action = ccoc_pkg::ccoc_act_t'(
		ctrl_ff[ccoc_pkg::UF_ACT_HI:ccoc_pkg::UF_ACT_LO]);
	assign cif.overflow_out_action = ccoc_pkg::ccoc_act_t'(
		ctrl_ff[ccoc_pkg::OF_ACT_HI:ccoc_pkg::OF_ACT_LO]);
	assign cif.match_out_action = ccoc_pkg::ccoc_act_t'(
		ctrl_ff[ccoc_pkg::MT_ACT_HI:ccoc_pkg::MT_ACT_LO]);
	assign cif.out_initial_state = ctrl_ff[ccoc_pkg::INIT_BIT];
	assign cif.mode = ccoc_pkg::ccoc_mode_t'(
		ctrl_ff[ccoc_pkg::MODE_HI:ccoc_pkg::MODE_LO]);
	assign out_invert = ctrl_ff[ccoc_pkg::INV_BIT];

	// Timer core events, same clock, no synchroniser
	assign cif.underflow = cnt_underflow;
	assign cif.overflow  = cnt_overflow;
	assign cif.match     = cmp_match;
	assign cif.running   = cnt_running;

	// ****************************************************************
	// Output engine
	// ****************************************************************
	ccoc_engine u_engine (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.cif     (cif.eng)
	);

	// ****************************************************************
	// Pin stage
	// ****************************************************************

	// Inversion only while the channel drives its output
	always_comb begin
		nxt_cc_out_en = cif.drive;
		nxt_cc_out    = 1'b0;
		if (cif.drive) begin
			nxt_cc_out = cif.level ^ out_invert;
		end
	end

	// Pin registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cc_out_ff    <= 1'b0;
			cc_out_en_ff <= 1'b0;
		end else if (ce) begin
			cc_out_ff    <= nxt_cc_out;
			cc_out_en_ff <= nxt_cc_out_en;
		end
	end

	assign cc_out    = cc_out_ff;
	assign cc_out_en = cc_out_en_ff;

endmodule

/* File: bench/ccoc_chk.sv */
// Port checker for the channel output control block
`timescale 1ns/1ns
module ccoc_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        cnt_running,
	input wire logic        cc_out,
	input wire logic        cc_out_en
);
	// ****
	// Quiet time counter
	// ****
	logic [2:0] quiet_ff;
	logic [2:0] nxt_quiet;

	// Cycles since the counter ran or a write landed
	always_comb begin
		nxt_quiet = quiet_ff;
		if (cnt_running || (pready && pwrite))
			nxt_quiet = 3'h0;
		else if (quiet_ff != 3'h7)
			nxt_quiet = quiet_ff + 3'h1;
	end

	// Register the quiet count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			quiet_ff <= 3'h0;
		else
			quiet_ff <= nxt_quiet;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_after_setup: assert property (psel && !penable && ce |=> pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready && ce |=> !pready)
		else $error("ready held too long");
	a_err_unmapped: assert property (pready |->
		pslverr == !(paddr inside {8'h00, 8'h04}))
		else $error("slave error does not match address");
	a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
		else $error("read data outside a read");
	a_ctrl_mask: assert property (pready && !pwrite && paddr == 8'h00
		|-> (prdata & ~ccoc_pkg::CTRL_MASK) == 32'h0)
		else $error("unused control bits read back");
	a_status_pin: assert property (pready && !pwrite && paddr == 8'h04
		|-> prdata[1] == $past(cc_out) && prdata[3] == $past(cc_out_en))
		else $error("status pin bits wrong");
	a_status_run: assert property (pready && !pwrite && paddr == 8'h04
		|-> prdata[2] == $past(cnt_running))
		else $error("status running bit wrong");
	a_stop_stable: assert property (quiet_ff >= 3'h6
		|-> $stable(cc_out) && $stable(cc_out_en))
		else $error("output moved while stopped");
	a_off_low: assert property (quiet_ff >= 3'h6 && !cc_out_en |-> !cc_out)
		else $error("output high while disabled");

	c_ctrl_write: cover property (pready && pwrite && paddr == 8'h00);
	c_out_rise: cover property ($rose(cc_out));
	c_bad_addr: cover property (pready && pslverr);
endmodule

/* File: bench/tb_top.sv */
// Self-checking testbench for the channel output control block
`timescale 1ns/1ns
module tb_top;
	logic        pclk;
	logic        presetn;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cnt_underflow;
	logic        cnt_overflow;
	logic        cmp_match;
	logic        cnt_running;
	logic        cc_out;
	logic        cc_out_en;
	logic [31:0] rd;
	logic [31:0] d;
	logic        er;
	int          err_total;
	int          n_checks;
	int          m;
	int          ini;
	int          inv;
	int          a;
	int          ev;
	int          lvl;
	int          en;

	ccoc_top dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
		.cnt_underflow, .cnt_overflow, .cmp_match, .cnt_running,
		.cc_out, .cc_out_en);

	// ****
	// Clock, tasks
	// ****
	always #4 pclk = ~pclk;

	// Compare one value and count it
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One APB transfer, waiting for pready
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk({31'h0, pready}, 32'h1, "pready");
	endtask

	// Verdict and end of run
	task close_out;
		if (err_total == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		#200000;
		err_total++;
		close_out;
	end

	// ****
	// Test sequence
	// ****
	initial begin
		pclk = 0;
		presetn = 0;
		ce = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{cnt_underflow, cnt_overflow, cmp_match, cnt_running} = '0;
		void'($urandom(14));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ccoc_pkg::OFS_CTRL, 32'h0);
		chk(rd, ccoc_pkg::CTRL_RST, "ctrl reset");
		repeat (6) begin
			d = $urandom & ccoc_pkg::CTRL_MASK;
			apb(1'b1, ccoc_pkg::OFS_CTRL, d);
			apb(1'b0, ccoc_pkg::OFS_CTRL, 32'h0);
			chk(rd, d, "ctrl");
		end
		apb(1'b0, 8'h08, 32'h0);
		chk({31'h0, er}, 32'h1, "slverr");
		chk(rd, 32'h0, "bad rdata");
		for (m = 0; m < 4; m++)
			for (ini = 0; ini < 2; ini++)
				for (inv = 0; inv < 2; inv++) begin
					apb(1'b1, 8'h00, m | (ini << 4) | (inv << 2));
					repeat (6) @(posedge pclk);
					en = (m >= 2);
					lvl = (m == 2) ? ini : 0;
					chk(cc_out, en ? (lvl ^ inv) : 0, "stop out");
					chk(cc_out_en, en, "out en");
				end
		for (ev = 0; ev < 3; ev++)
			for (a = 0; a < 4; a++) begin
				ini = $urandom % 2;
				inv = $urandom % 2;
				m = 2 + $urandom % 2;
				d = (a << (12 - 2 * ev)) | (ini << 4) | (inv << 2) | m;
				apb(1'b1, 8'h00, d);
				repeat (6) @(posedge pclk);
				cnt_running <= 1'b1;
				repeat (4) @(posedge pclk);
				cnt_underflow <= (ev == 0);
				cnt_overflow <= (ev == 1);
				cmp_match <= (ev == 2);
				@(posedge pclk);
				{cnt_underflow, cnt_overflow, cmp_match} <= 3'h0;
				repeat (3) @(posedge pclk);
				lvl = (m == 2) ? ini : 0;
				lvl = (a == 1) ? !lvl : (a == 2) ? 0 : (a == 3) ? 1 : lvl;
				chk(cc_out, lvl ^ inv, "event out");
				apb(1'b0, ccoc_pkg::OFS_STATUS, 32'h0);
				chk(rd[3:0], {2'h3, 1'(lvl ^ inv), 1'(lvl)}, "status");
				cnt_running <= 1'b0;
			end
		// Match during a frozen cycle must be lost
		apb(1'b1, ccoc_pkg::OFS_CTRL, 32'h0000_0102);
		repeat (6) @(posedge pclk);
		cnt_running <= 1'b1;
		repeat (4) @(posedge pclk);
		ce <= 1'b0;
		cmp_match <= 1'b1;
		@(posedge pclk);
		ce <= 1'b1;
		cmp_match <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(cc_out, 0, "frozen out");
		cnt_running <= 1'b0;
		repeat (4) @(posedge pclk);
		close_out;
	end
endmodule

// Attach the port checker to the design top
bind ccoc_top ccoc_chk chk_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .cnt_running, .cc_out, .cc_out_en);
